// ### encoder_speed_feedback_monitor.sv
`timescale 1ns/100ps
`include "speed_feedback_defines.svh"
module encoder_speed_feedback_monitor
  import speed_feedback_pkg::*;
#(
  parameter int TICK_CYCLES = `TICK_CYCLES,
  parameter int WINDOW_CYCLES = `WINDOW_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  input wire logic phase_a,
  input wire logic phase_b,
  input wire logic running,
  input wire logic run_reverse,
  input wire logic dc_braking,
  input wire logic closed_loop_vector,
  input wire logic accelerating,
  input wire logic signed [31:0] speed_reference,
  output logic monitor_pulse,
  output logic encoder_open_fault,
  output logic overspeed_fault,
  output logic speed_deviation_fault,
  output logic stop_request,
  output logic [1:0] stop_method,
  output logic speed_integral_enable
);
  localparam logic [63:0] RPM_SCALE = 64'(`RPM_PER_PPS * (`SECOND_CYCLES / WINDOW_CYCLES));
  localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);
  localparam logic [31:0] WINDOW_LAST = 32'(WINDOW_CYCLES - 1);

  state_type st_reg;
  state_type st_next;
  logic tick;
  logic win_end;
  logic a_rise;
  logic any_edge;
  logic quad;
  logic fwd;
  logic signed [15:0] step;
  logic [15:0] mag;
  logic [15:0] ppr_eff;
  logic [9:0] gear_l;
  logic [9:0] gear_m;
  logic [63:0] num;
  logic [63:0] den;
  logic [63:0] rpm_mag;
  logic [31:0] abs_speed;
  logic signed [32:0] err;
  logic [32:0] abs_err;
  logic [31:0] abs_ref;
  logic os_cond;
  logic dev_cond;
  logic agree;
  logic open_arm;
  logic open_set;
  logic os_set;
  logic dev_set;
  logic clr;
  logic mon_enable;
  logic mon_out;

  ////////////////////////////////////////////////////////////////////////////////

  always_comb begin
    st_next = st_reg;
    tick = (st_reg.tick_timer == TICK_LAST);
    win_end = (st_reg.win_timer == WINDOW_LAST);
    st_next.tick_timer = tick ? 32'h0000_0000 : st_reg.tick_timer + 32'h0000_0001;
    st_next.win_timer = win_end ? 32'h0000_0000 : st_reg.win_timer + 32'h0000_0001;
    st_next.a_prev = phase_a;
    st_next.b_prev = phase_b;
    a_rise = phase_a & ~st_reg.a_prev;
    any_edge = (phase_a ^ st_reg.a_prev) | (phase_b ^ st_reg.b_prev);
    quad = (st_reg.card == `CARD_QUAD_COMP) || (st_reg.card == `CARD_QUAD_LD);

    // Only rising A edges are counted, so the count is in single-phase pulses.
    if (quad) begin
      fwd = (phase_b == st_reg.dir_pol);
    end else begin
      fwd = ~run_reverse;
    end
    step = !a_rise ? 16'sh0000 : fwd ? 16'sh0001 : -16'sh0001;
    st_next.win_count = win_end ? step : st_reg.win_count + step;

    ////////////////////////////////////////////////////////////////////////////

    // The divide is combinational and runs every cycle; only its result at the window end is loaded into speed_rpm.
    mag = st_reg.win_count[15] ? 16'(-st_reg.win_count) : st_reg.win_count;
    ppr_eff = (st_reg.ppr == 16'h0000) ? 16'h0001 : st_reg.ppr;
    if (st_reg.gear_motor == 10'h000 || st_reg.gear_load == 10'h000) begin
      gear_l = 10'h001;
      gear_m = 10'h001;
    end else begin
      gear_l = st_reg.gear_load;
      gear_m = st_reg.gear_motor;
    end
    num = 64'(mag) * RPM_SCALE * 64'(gear_l);
    den = 64'(ppr_eff) * 64'(gear_m);
    rpm_mag = num / den;
    if (win_end) begin
      st_next.speed_rpm = st_reg.win_count[15] ? -32'(rpm_mag) : 32'(rpm_mag);
    end

    ////////////////////////////////////////////////////////////////////////////

    abs_speed = st_reg.speed_rpm[31] ? 32'(-st_reg.speed_rpm) : st_reg.speed_rpm;
    abs_ref = speed_reference[31] ? 32'(-speed_reference) : speed_reference;
    err = 33'(speed_reference) - 33'(st_reg.speed_rpm);
    abs_err = err[32] ? 33'(-err) : err;
    os_cond = (40'(abs_speed) * 40'd100) > (40'(st_reg.os_level) * 40'(st_reg.max_freq));
    dev_cond = (41'(abs_err) * 41'd100) > (41'(st_reg.dev_level) * 41'(st_reg.max_freq));
    agree = abs_err <= 33'(st_reg.agree_band);
    open_arm = running && !dc_braking
      && (40'(abs_ref) * 40'(`PERCENT_FULL) >= 40'(st_reg.max_freq));

    // A pulse on either phase proves the cable; any drop of arming restarts the wait.
    if (!open_arm || any_edge) begin
      st_next.open_timer = 8'h00;
    end else if (tick && st_reg.open_timer != 8'hFF) begin
      st_next.open_timer = st_reg.open_timer + 8'h01;
    end
    open_set = open_arm && (st_reg.open_timer > 8'(st_reg.open_delay));

    if (!os_cond) begin
      st_next.os_timer = 8'h00;
    end else if (tick && st_reg.os_timer != 8'hFF) begin
      st_next.os_timer = st_reg.os_timer + 8'h01;
    end
    os_set = os_cond && (st_reg.os_timer > 8'(st_reg.os_delay));

    case (st_reg.dev_state)
      DEV_DISARMED: begin
        if (running && agree) begin
          st_next.dev_state = DEV_ARMED;
        end
      end
      DEV_ARMED: begin
        if (!running) begin
          st_next.dev_state = DEV_DISARMED;
        end
      end
      default: begin
        st_next.dev_state = DEV_DISARMED;
      end
    endcase
    if (st_reg.dev_state != DEV_ARMED || !dev_cond) begin
      st_next.dev_timer = 8'h00;
    end else if (tick && st_reg.dev_timer != 8'hFF) begin
      st_next.dev_timer = st_reg.dev_timer + 8'h01;
    end
    dev_set = (st_reg.dev_state == DEV_ARMED) && dev_cond
      && (st_reg.dev_timer > 8'(st_reg.dev_delay));

    ////////////////////////////////////////////////////////////////////////////

    clr = wr_en && (addr == `ADDR_CONTROL) && wr_data[`CTRL_FAULT_CLEAR_BIT];
    // A fault that fires in the cycle of a clear survives it.
    st_next.open_fault = open_set | (st_reg.open_fault & ~clr);
    st_next.os_fault = os_set | (st_reg.os_fault & ~clr);
    st_next.dev_fault = dev_set | (st_reg.dev_fault & ~clr);
    st_next.stop_request = st_next.open_fault | st_next.os_fault | st_next.dev_fault;
    // The first fault to fire owns the stop method until all faults are cleared.
    if (!st_reg.stop_request || clr) begin
      if (open_set) begin
        st_next.stop_method = st_reg.open_method;
      end else if (os_set) begin
        st_next.stop_method = st_reg.os_method;
      end else if (dev_set) begin
        st_next.stop_method = st_reg.dev_method;
      end
    end
    st_next.integ_out = !closed_loop_vector || !accelerating || st_reg.integ_en;

    ////////////////////////////////////////////////////////////////////////////

    if (wr_en) begin
      case (addr)
        `ADDR_PULSES_PER_REV: st_next.ppr = wr_data[15:0];
        `ADDR_MOTOR_GEAR: begin
          st_next.gear_motor = (wr_data > 32'(`GEAR_MAX)) ? `GEAR_MAX : wr_data[9:0];
        end
        `ADDR_LOAD_GEAR: begin
          st_next.gear_load = (wr_data > 32'(`GEAR_MAX)) ? `GEAR_MAX : wr_data[9:0];
        end
        `ADDR_CONTROL: begin
          st_next.dir_pol = wr_data[`CTRL_POLARITY_BIT];
          st_next.integ_en = wr_data[`CTRL_INTEGRAL_BIT];
          st_next.card = wr_data[`CTRL_CARD_LSB +: 2];
        end
        `ADDR_MONITOR_DIVIDE: st_next.mon_div = wr_data[7:0];
        `ADDR_OPEN_DELAY: st_next.open_delay = wr_data[6:0];
        `ADDR_OVERSPEED_LEVEL: begin
          st_next.os_level = (wr_data > 32'(`OVERSPEED_LEVEL_MAX)) ?
            `OVERSPEED_LEVEL_MAX : wr_data[6:0];
        end
        `ADDR_OVERSPEED_DELAY: begin
          st_next.os_delay = (wr_data > 32'(`OVERSPEED_DELAY_MAX)) ?
            `OVERSPEED_DELAY_MAX : wr_data[4:0];
        end
        `ADDR_DEVIATION_LEVEL: begin
          st_next.dev_level = (wr_data > 32'(`DEVIATION_LEVEL_MAX)) ?
            `DEVIATION_LEVEL_MAX : wr_data[5:0];
        end
        `ADDR_DEVIATION_DELAY: begin
          st_next.dev_delay = (wr_data > 32'(`DEVIATION_DELAY_MAX)) ?
            `DEVIATION_DELAY_MAX : wr_data[6:0];
        end
        `ADDR_STOP_METHODS: begin
          st_next.open_method = wr_data[`STOP_OPEN_LSB +: 2];
          st_next.os_method = wr_data[`STOP_OVERSPEED_LSB +: 2];
          st_next.dev_method = wr_data[`STOP_DEVIATION_LSB +: 2];
        end
        `ADDR_AGREE_BAND: st_next.agree_band = wr_data[15:0];
        `ADDR_MAX_FREQUENCY: st_next.max_freq = wr_data[15:0];
        default: begin
        end
      endcase
    end

    st_next.rd_data = 32'h0000_0000;
    if (rd_en) begin
      case (addr)
        `ADDR_PULSES_PER_REV: st_next.rd_data = 32'(st_reg.ppr);
        `ADDR_MOTOR_GEAR: st_next.rd_data = 32'(st_reg.gear_motor);
        `ADDR_LOAD_GEAR: st_next.rd_data = 32'(st_reg.gear_load);
        `ADDR_CONTROL: st_next.rd_data = 32'({st_reg.card, st_reg.integ_en, st_reg.dir_pol});
        `ADDR_MONITOR_DIVIDE: st_next.rd_data = 32'(st_reg.mon_div);
        `ADDR_OPEN_DELAY: st_next.rd_data = 32'(st_reg.open_delay);
        `ADDR_OVERSPEED_LEVEL: st_next.rd_data = 32'(st_reg.os_level);
        `ADDR_OVERSPEED_DELAY: st_next.rd_data = 32'(st_reg.os_delay);
        `ADDR_DEVIATION_LEVEL: st_next.rd_data = 32'(st_reg.dev_level);
        `ADDR_DEVIATION_DELAY: st_next.rd_data = 32'(st_reg.dev_delay);
        `ADDR_STOP_METHODS: begin
          st_next.rd_data = 32'({st_reg.dev_method, st_reg.os_method, st_reg.open_method});
        end
        `ADDR_AGREE_BAND: st_next.rd_data = 32'(st_reg.agree_band);
        `ADDR_MAX_FREQUENCY: st_next.rd_data = 32'(st_reg.max_freq);
        `ADDR_SPEED: st_next.rd_data = st_reg.speed_rpm;
        `ADDR_STATUS: begin
          st_next.rd_data = 32'({st_reg.dev_state == DEV_ARMED, st_reg.stop_method,
            st_reg.stop_request, st_reg.dev_fault, st_reg.os_fault, st_reg.open_fault});
        end
        default: st_next.rd_data = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.ppr <= `RST_PULSES_PER_REV;
      st_reg.gear_motor <= `RST_GEAR;
      st_reg.gear_load <= `RST_GEAR;
      st_reg.mon_div <= `RST_MONITOR_DIVIDE;
      st_reg.open_delay <= `RST_OPEN_DELAY;
      st_reg.os_level <= `RST_OVERSPEED_LEVEL;
      st_reg.os_delay <= `RST_OVERSPEED_DELAY;
      st_reg.dev_level <= `RST_DEVIATION_LEVEL;
      st_reg.dev_delay <= `RST_DEVIATION_DELAY;
      st_reg.open_method <= `RST_STOP_METHOD;
      st_reg.os_method <= `RST_STOP_METHOD;
      st_reg.dev_method <= `RST_STOP_METHOD;
      st_reg.agree_band <= `RST_AGREE_BAND;
      st_reg.max_freq <= `RST_MAX_FREQUENCY;
      st_reg.dev_state <= DEV_DISARMED;
      st_reg.integ_out <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  assign mon_enable = (st_reg.card == `CARD_QUAD_COMP);

  monitor_pulse_divider u_divider (
    .clk_sys(clk_sys),
    .rst(rst),
    .pulse_in(a_rise),
    .enable(mon_enable),
    .setting(st_reg.mon_div),
    .pulse_out(mon_out)
  );

  assign rd_data = st_reg.rd_data;
  assign monitor_pulse = mon_out;
  assign encoder_open_fault = st_reg.open_fault;
  assign overspeed_fault = st_reg.os_fault;
  assign speed_deviation_fault = st_reg.dev_fault;
  assign stop_request = st_reg.stop_request;
  assign stop_method = st_reg.stop_method;
  assign speed_integral_enable = st_reg.integ_out;

  ////////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_speed_window_load: assert property (win_end |=> st_reg.speed_rpm == $past(st_reg.win_count[15] ? -32'(rpm_mag) : 32'(rpm_mag)))
    else $error("speed not loaded at window end");
  a_quad_fwd_count: assert property (quad && a_rise && !win_end && phase_b == st_reg.dir_pol |=> st_reg.win_count == $past(st_reg.win_count) + 16'sh0001)
    else $error("forward quadrature pulse not counted up");
  a_gear_clamp: assert property (wr_en && addr == `ADDR_MOTOR_GEAR && wr_data > 32'(`GEAR_MAX) |=> st_reg.gear_motor == `GEAR_MAX)
    else $error("gear teeth not limited");
  a_integral_hold: assert property (closed_loop_vector && accelerating && !st_reg.integ_en |=> !speed_integral_enable)
    else $error("integral left on during ramp");
  a_monitor_card_gate: assert property (monitor_pulse |-> $past(st_reg.card) == `CARD_QUAD_COMP)
    else $error("monitor pulse with wrong card");
  a_open_armed_only: assert property ($rose(encoder_open_fault) |-> $past(open_arm) && $past(st_reg.open_timer) > 8'($past(st_reg.open_delay)))
    else $error("open fault raised while unarmed");
  a_timer_restart: assert property (!os_cond |=> st_reg.os_timer == 8'h00)
    else $error("overspeed timer kept running");
  a_os_needs_delay: assert property ($rose(overspeed_fault) |-> $past(st_reg.os_timer) > 8'($past(st_reg.os_delay)))
    else $error("overspeed raised before delay");
  a_dev_needs_arm: assert property ($rose(speed_deviation_fault) |-> $past(st_reg.dev_state) == DEV_ARMED)
    else $error("deviation raised before agreement");
  a_os_stop_method: assert property ($rose(overspeed_fault) && !$past(stop_request) && !$rose(encoder_open_fault) |-> stop_method == $past(st_reg.os_method))
    else $error("overspeed stop method not applied");
  a_open_stop_method: assert property ($rose(encoder_open_fault) && !$past(stop_request) |-> stop_method == $past(st_reg.open_method) && stop_request)
    else $error("open stop method not applied");

  c_open_fault: cover property ($rose(encoder_open_fault));
  c_overspeed: cover property ($rose(overspeed_fault));
  c_deviation: cover property ($rose(speed_deviation_fault));
  c_monitor: cover property (monitor_pulse ##1 !monitor_pulse);
endmodule : encoder_speed_feedback_monitor

// ### speed_feedback_defines.svh
//
// Overview of operation
// - Pulses per revolution scale every speed figure.
// - Polarity setting picks forward leading phase.
// - Speed equals rate times sixty, geared.
// - Gear teeth 0 to 1000; zero means unity.
// - Integral enable keeps integral during ramps.
// - Monitor divides pulses by (1+n)/m.
// - Monitor ratio stays between 1/32 and 1.
// - Monitor output only with complementary quadrature card.
// - Open detect armed running, reference 1%, no braking.
// - Open delay defaults 2.0 s, pulseless.
// - Open fault stops with its chosen method.
// - Overspeed fault after level exceeded beyond delay.
// - Overspeed level 0-120 default 115, delay 0-2.0.
// - Overspeed fault stops with its chosen method.
// - Deviation armed after agreement, fault beyond delay.
// - Deviation level 0-50 default 10, delay 0.5.
// - Deviation fault stops with its chosen method.
//
`ifndef SPEED_FEEDBACK_DEFINES_SVH
`define SPEED_FEEDBACK_DEFINES_SVH
`define CLK_PERIOD_NS 4
`define SECOND_NS 1000000000
`define TICK_TIME_NS 100000000
`define WINDOW_TIME_NS 10000000
`define TICK_CYCLES (`TICK_TIME_NS / `CLK_PERIOD_NS)
`define WINDOW_CYCLES (`WINDOW_TIME_NS / `CLK_PERIOD_NS)
`define SECOND_CYCLES (`SECOND_NS / `CLK_PERIOD_NS)
`define RPM_PER_PPS 60
`define PERCENT_FULL 100
`define ADDR_PULSES_PER_REV 8'h00
`define ADDR_MOTOR_GEAR 8'h04
`define ADDR_LOAD_GEAR 8'h08
`define ADDR_CONTROL 8'h0C
`define ADDR_MONITOR_DIVIDE 8'h10
`define ADDR_OPEN_DELAY 8'h14
`define ADDR_OVERSPEED_LEVEL 8'h18
`define ADDR_OVERSPEED_DELAY 8'h1C
`define ADDR_DEVIATION_LEVEL 8'h20
`define ADDR_DEVIATION_DELAY 8'h24
`define ADDR_STOP_METHODS 8'h28
`define ADDR_AGREE_BAND 8'h2C
`define ADDR_MAX_FREQUENCY 8'h30
`define ADDR_SPEED 8'h34
`define ADDR_STATUS 8'h38
`define CTRL_POLARITY_BIT 0
`define CTRL_INTEGRAL_BIT 1
`define CTRL_CARD_LSB 2
`define CTRL_FAULT_CLEAR_BIT 4
`define STOP_OPEN_LSB 0
`define STOP_OVERSPEED_LSB 2
`define STOP_DEVIATION_LSB 4
`define CARD_SINGLE_OC 2'h0
`define CARD_QUAD_COMP 2'h1
`define CARD_SINGLE_LD 2'h2
`define CARD_QUAD_LD 2'h3
`define GEAR_MAX 10'h3E8
`define OVERSPEED_LEVEL_MAX 7'h78
`define OVERSPEED_DELAY_MAX 5'h14
`define DEVIATION_LEVEL_MAX 6'h32
`define DEVIATION_DELAY_MAX 7'h64
`define MONITOR_N_STEP 8'h64
`define MONITOR_M_MAX 8'h20
`define RST_PULSES_PER_REV 16'h0400
`define RST_GEAR 10'h000
`define RST_MONITOR_DIVIDE 8'h01
`define RST_OPEN_DELAY 7'h14
`define RST_OVERSPEED_LEVEL 7'h73
`define RST_OVERSPEED_DELAY 5'h00
`define RST_DEVIATION_LEVEL 6'h0A
`define RST_DEVIATION_DELAY 7'h05
`define RST_STOP_METHOD 2'h1
`define RST_AGREE_BAND 16'h0014
`define RST_MAX_FREQUENCY 16'h0708
`endif

// ### speed_feedback_pkg.sv
package speed_feedback_pkg;
  typedef enum logic {DEV_DISARMED, DEV_ARMED} dev_state_type;

  typedef struct packed {
    logic [7:0] acc;
    logic pulse;
  } divider_state_type;

  typedef struct packed {
    logic [15:0] ppr;
    logic [9:0] gear_motor;
    logic [9:0] gear_load;
    logic dir_pol;
    logic integ_en;
    logic [1:0] card;
    logic [7:0] mon_div;
    logic [6:0] open_delay;
    logic [6:0] os_level;
    logic [4:0] os_delay;
    logic [5:0] dev_level;
    logic [6:0] dev_delay;
    logic [1:0] open_method;
    logic [1:0] os_method;
    logic [1:0] dev_method;
    logic [15:0] agree_band;
    logic [15:0] max_freq;
    logic a_prev;
    logic b_prev;
    logic signed [15:0] win_count;
    logic [31:0] win_timer;
    logic [31:0] tick_timer;
    logic signed [31:0] speed_rpm;
    logic [7:0] open_timer;
    logic [7:0] os_timer;
    logic [7:0] dev_timer;
    dev_state_type dev_state;
    logic open_fault;
    logic os_fault;
    logic dev_fault;
    logic stop_request;
    logic [1:0] stop_method;
    logic integ_out;
    logic [31:0] rd_data;
  } state_type;
endpackage : speed_feedback_pkg

// ### monitor_pulse_divider.sv
`timescale 1ns/100ps
`include "speed_feedback_defines.svh"
module monitor_pulse_divider
  import speed_feedback_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic pulse_in,
  input wire logic enable,
  input wire logic [7:0] setting,
  output logic pulse_out
);
  divider_state_type st_reg;
  divider_state_type st_next;
  logic [7:0] m_raw;
  logic [7:0] m_eff;
  logic [7:0] inc;
  logic [8:0] sum;
  logic [7:0] base;

  always_comb begin
    st_next = st_reg;
    st_next.pulse = 1'b0;
    m_raw = (setting >= `MONITOR_N_STEP) ? setting - `MONITOR_N_STEP : setting;
    m_eff = (m_raw == 8'h00) ? 8'h01 : (m_raw > `MONITOR_M_MAX) ? `MONITOR_M_MAX : m_raw;
    inc = (setting >= `MONITOR_N_STEP) ? 8'h02 : 8'h01;
    // A ratio above one cannot make more pulses than arrive, so it is held at one.
    if (inc > m_eff) begin
      inc = m_eff;
    end
    // A residue at or above the new divisor is dropped, so the accumulator stays below the new divisor.
    base = (st_reg.acc >= m_eff) ? 8'h00 : st_reg.acc;
    sum = {1'b0, base} + {1'b0, inc};
    if (!enable) begin
      st_next.acc = 8'h00;
    end else if (pulse_in) begin
      if (sum >= {1'b0, m_eff}) begin
        st_next.acc = 8'(sum - {1'b0, m_eff});
        st_next.pulse = 1'b1;
      end else begin
        st_next.acc = sum[7:0];
      end
    end else begin
      st_next.acc = base;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pulse_out = st_reg.pulse;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_acc_below_m: assert property (enable |=> st_reg.acc < $past(m_eff))
    else $error("monitor accumulator reached divisor");
  a_no_pulse_idle: assert property (!(pulse_in && enable) |=> !pulse_out)
    else $error("monitor pulse without encoder pulse");
endmodule : monitor_pulse_divider

// ### encoder_model.sv
`timescale 1ns/100ps
module encoder_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic run,
  input wire logic forward,
  input wire logic [3:0] step,
  output logic phase_a,
  output logic phase_b
);
  logic [1:0] pos_reg;
  logic [3:0] cnt_reg;
  // A stopped shaft keeps its angle, so both phases hold their level between runs.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pos_reg <= 2'h0;
      cnt_reg <= 4'h0;
    end else if (run && cnt_reg >= step - 4'h1) begin
      cnt_reg <= 4'h0;
      pos_reg <= forward ? pos_reg + 2'h1 : pos_reg - 2'h1;
    end else if (run) begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
  //////////////////////////////////////////////////
  // Gray order: forward turning puts phase A a quarter period ahead of phase B.
  assign phase_a = pos_reg[1] ^ pos_reg[0];
  assign phase_b = pos_reg[1];
endmodule : encoder_model

// ### encoder_speed_feedback_monitor_tb.sv
`timescale 1ns/100ps
module encoder_speed_feedback_monitor_tb import speed_feedback_pkg::*;;
  logic clk_sys, rst, wr_en, rd_en, running, run_reverse, dc_braking, closed_loop_vector;
  logic accelerating, enc_run, enc_fwd, monitor_pulse, stop_request, speed_integral_enable;
  logic phase_a, phase_b, a_seen, pol, neg, encoder_open_fault, overspeed_fault;
  logic speed_deviation_fault;
  logic [7:0] addr;
  logic [31:0] wr_data, rd_data, d;
  logic signed [31:0] speed_reference;
  logic [1:0] stop_method, card;
  logic [2:0] faults;
  logic [3:0] step;
  int bad_count, cmp_count, seed, cyc, rises, pulses, ppr, gl, gm, c, w, num, den, lo;
  logic [7:0] ra [6] = '{8'h14, 8'h18, 8'h20, 8'h24, 8'h04, 8'h3C};
  logic [31:0] rv [6] = '{32'h14, 32'h73, 32'hA, 32'h5, 32'h0, 32'h0};
  logic [7:0] ms [6] = '{8'h01, 8'h02, 8'h20, 8'h65, 8'h84, 8'h02};
  assign faults = {speed_deviation_fault, overspeed_fault, encoder_open_fault};
  encoder_speed_feedback_monitor #(.TICK_CYCLES(20), .WINDOW_CYCLES(250)) u_dut (
    .clk_sys(clk_sys), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .phase_a(phase_a), .phase_b(phase_b),
    .running(running), .run_reverse(run_reverse), .dc_braking(dc_braking),
    .closed_loop_vector(closed_loop_vector), .accelerating(accelerating),
    .speed_reference(speed_reference), .monitor_pulse(monitor_pulse),
    .encoder_open_fault(encoder_open_fault), .overspeed_fault(overspeed_fault),
    .speed_deviation_fault(speed_deviation_fault), .stop_request(stop_request),
    .stop_method(stop_method), .speed_integral_enable(speed_integral_enable));
  encoder_model u_enc (.clk_sys(clk_sys), .rst(rst), .run(enc_run), .forward(enc_fwd),
    .step(step), .phase_a(phase_a), .phase_b(phase_b));
  ////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    a_seen <= phase_a;
    if (phase_a === 1'b1 && a_seen === 1'b0) rises++;
    if (monitor_pulse === 1'b1) pulses++;
    cyc++;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test;
    if (bad_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    addr <= a;
    wr_data <= v;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    @(negedge clk_sys);
    d = rd_data;
  endtask : rd
  // A fault that never comes counts against the run and ends it at once.
  task automatic wait_fault(input int b, input int lim);
    for (w = 0; w < lim && faults[b] !== 1'b1; w++) @(posedge clk_sys);
    if (w == lim) begin
      check(32'h0, 32'h1);
      stop_test();
    end
  endtask : wait_fault
  function automatic logic [31:0] spd(input longint c, p, l, m, input logic neg);
    longint v;
    if (l > 1000) l = 1000;
    if (m > 1000) m = 1000;
    if (l == 0 || m == 0) begin
      l = 1;
      m = 1;
    end
    v = c * 60000000 * l / (p * m);
    return 32'(neg ? -v : v);
  endfunction : spd
  ////////////////////////////////////////////////////////////
  initial begin
    {rst, wr_en, rd_en, running, run_reverse, dc_braking, closed_loop_vector} = 7'h40;
    {accelerating, enc_run, enc_fwd, addr, wr_data, speed_reference} = '0;
    {bad_count, cmp_count, cyc, rises, pulses, seed, step} = {160'h0, 32'd70331, 4'h2};
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    foreach (ra[i]) begin
      rd(ra[i]);
      check(d, rv[i]);
    end
    wr(8'h18, 32'd200);
    rd(8'h18);
    check(d, 32'd120);
    wr(8'h04, 32'd2000);
    rd(8'h04);
    check(d, 32'd1000);
    for (int i = 0; i < 8; i++) begin
      {closed_loop_vector, accelerating} <= 2'(i >> 1);
      wr(8'h0C, 32'(i[0]) << 1);
      repeat (3) @(posedge clk_sys);
      check(speed_integral_enable, !(i[2] && i[1] && !i[0]));
    end
    for (int i = 0; i < 6; i++) begin
      step <= 4'(2 + $unsigned($random(seed)) % 8);
      {enc_fwd, run_reverse, pol, card} <= 5'($random(seed));
      ppr = 1000 + $unsigned($random(seed)) % 4000;
      gl = $unsigned($random(seed)) % 1201;
      gm = $unsigned($random(seed)) % 1201;
      wr(8'h00, ppr);
      wr(8'h04, gm);
      wr(8'h08, gl);
      wr(8'h0C, {card, 1'b0, pol});
      enc_run <= 1'b1;
      repeat (600) @(posedge clk_sys);
      rd(8'h34);
      neg = card[0] ? (enc_fwd == pol) : run_reverse;
      c = 250 / (4 * step);
      check(d === spd(c, ppr, gl, gm, neg) || d === spd(c + 1, ppr, gl, gm, neg), 1);
    end
    foreach (ms[i]) begin
      enc_run <= 1'b0;
      wr(8'h10, ms[i]);
      wr(8'h0C, i < 5 ? 32'h4 : 32'h0);
      repeat (4) @(posedge clk_sys);
      {rises, pulses} = '0;
      enc_run <= 1'b1;
      repeat (400) @(posedge clk_sys);
      enc_run <= 1'b0;
      repeat (4) @(posedge clk_sys);
      num = 1 + (ms[i] >= 100);
      den = ms[i] - 100 * (num - 1);
      if (num > den) num = den;
      lo = i < 5 ? rises * num / den : 0;
      check(pulses >= lo && pulses <= lo + (i < 5), 1);
    end
    {step, enc_fwd} <= 5'h5;
    wr(8'h28, 32'h1B);
    wr(8'h04, 32'h0);
    wr(8'h00, 32'd60000);
    wr(8'h18, 32'd100);
    wr(8'h1C, 32'd20);
    repeat (600) @(posedge clk_sys);
    wr(8'h0C, 32'h14);
    while (cyc % 250 != 60) @(posedge clk_sys);
    enc_run <= 1'b1;
    repeat (100) @(posedge clk_sys);
    enc_run <= 1'b0;
    repeat (700) @(posedge clk_sys);
    check(overspeed_fault, 1'b0);
    enc_run <= 1'b1;
    wait_fault(1, 2000);
    check(w >= 400, 1);
    check({stop_request, stop_method}, 3'h6);
    enc_run <= 1'b0;
    wr(8'h2C, 32'h0);
    repeat (600) @(posedge clk_sys);
    wr(8'h0C, 32'h14);
    {running, dc_braking, speed_reference} <= {2'h3, 32'd1000};
    repeat (600) @(posedge clk_sys);
    check(encoder_open_fault, 1'b0);
    {dc_braking, speed_reference} <= {1'b0, 32'd10};
    repeat (600) @(posedge clk_sys);
    check(encoder_open_fault, 1'b0);
    speed_reference <= 32'd1000;
    wait_fault(0, 1000);
    check(w >= 400, 1);
    check(stop_method, 2'h3);
    running <= 1'b0;
    wr(8'h14, 32'd127);
    wr(8'h0C, 32'h14);
    running <= 1'b1;
    repeat (600) @(posedge clk_sys);
    check(speed_deviation_fault, 1'b0);
    wr(8'h2C, 32'hFFFF);
    wait_fault(2, 1000);
    check(w >= 100, 1);
    check(stop_method, 2'h1);
    stop_test();
  end
endmodule : encoder_speed_feedback_monitor_tb
